// ===== ric_pkg.sv
// Purpose: shared constants for the reference input configuration registers
// Assumes: AHB-Lite word access, one register per aligned word
// Notes: printed offsets are register indices; byte address is four times the index
package ric_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_PWRDN = 12'h600;
    localparam logic [11:0] IDX_FAMILY = 12'h601;
    localparam logic [11:0] IDX_PRIO = 12'h602;
    localparam logic [11:0] IDX_STATUS = 12'h603;
    localparam logic [13:0] ADDR_PWRDN = {IDX_PWRDN, 2'h0};
    localparam logic [13:0] ADDR_FAMILY = {IDX_FAMILY, 2'h0};
    localparam logic [13:0] ADDR_PRIO = {IDX_PRIO, 2'h0};
    localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int NUM_REF = 4;
    localparam int PWRDN_LSB = 0;
    localparam int PWRDN_W = 4;
    localparam int FIELD_W = 2;
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_POSONLY_LSB = 4;
    localparam int STAT_SLEEP_BIT = 8;
    localparam logic [3:0] PWRDN_RST = 4'h0;
    localparam logic [7:0] FAMILY_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic SLEEP_RST = 1'h0;
    localparam logic [3:0] POSONLY_RST = 4'h0;

    // ------------------------------------------------------------
    // signalling family codes
    // ------------------------------------------------------------
    localparam logic [1:0] FAM_DIFF = 2'h0;
    localparam logic [1:0] FAM_CMOS_LOW = 2'h1;
    localparam logic [1:0] FAM_CMOS_MID = 2'h2;
    localparam logic [1:0] FAM_CMOS_HIGH = 2'h3;

    // ------------------------------------------------------------
    // bus encodings and data phase state
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_WRITE = 1'b1
    } ric_phase_type;

endpackage

// ===== ric_regs_sva.sv
// Purpose: concurrent checks on the reference input configuration registers
// Assumes: one clock domain, zero wait state bus slave
// Notes: sees only the ports of ric_regs_top
`timescale 1ns/1ps
module ric_regs_sva (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // receiver controls and received levels
    input wire logic [3:0] rxPowerDown,
    input wire logic rxDeepSleep,
    input wire logic [7:0] rxFamily,
    input wire logic [3:0] rxPosLegOnly,
    input wire logic [7:0] refPriority,
    input wire logic [3:0] refLevel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wrAny;
    logic wrPd;
    logic wrFm;
    logic wrPr;
    assign wrAny = hsel && hready && htrans[1] && hwrite;
    assign wrPd = wrAny && (haddr[13:2] == ric_pkg::IDX_PWRDN);
    assign wrFm = wrAny && (haddr[13:2] == ric_pkg::IDX_FAMILY);
    assign wrPr = wrAny && (haddr[13:2] == ric_pkg::IDX_PRIO);
    chk_sleep_all: assert property (rxDeepSleep == (rxPowerDown == 4'hF))
        else $error("deep sleep does not match power-down bits");
    chk_posleg_map: assert property (rxPosLegOnly == {|rxFamily[7:6], |rxFamily[5:4],
        |rxFamily[3:2], |rxFamily[1:0]}) else $error("positive leg select wrong");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_pd_write: assert property (wrPd |=> ##1 rxPowerDown == $past(hwdata[3:0]))
        else $error("power-down write not taken");
    chk_fam_write: assert property (wrFm |=> ##1 rxFamily == $past(hwdata[7:0]))
        else $error("family write not taken");
    chk_prio_write: assert property (wrPr |=> ##1 refPriority == $past(hwdata[7:0]))
        else $error("priority write not taken");
    chk_prio_hold: assert property ($changed(refPriority) |-> $past(wrPr, 2))
        else $error("priority changed without write");
    chk_fam_hold: assert property ($changed(rxFamily) |-> $past(wrFm, 2))
        else $error("family changed without write");
    chk_lane_off: assert property ((rxPowerDown & $past(rxPowerDown) & refLevel) == 4'h0)
        else $error("powered-down lane shows a level");
    chk_sleep_off: assert property (rxDeepSleep ##1 rxDeepSleep |-> refLevel == 4'h0)
        else $error("level seen in deep sleep");
    cover property (wrPd);
    cover property ($rose(rxDeepSleep));
    cover property (rxPosLegOnly == 4'hF);
endmodule // ric_regs_sva

bind ric_regs_top ric_regs_sva u_sva (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hreadyout, .hresp, .rxPowerDown, .rxDeepSleep, .rxFamily, .rxPosLegOnly,
    .refPriority, .refLevel);

// ===== ric_regs_top.sv
// Purpose: configuration registers for four reference clock receivers
// Assumes: single AHB-Lite master, word transfers, 100 MHz clk
// Notes: zero wait state slave; unmapped reads return zero, writes ignored
//   byte addresses are four times the register index: power-down 0x1800,
//   family 0x1804, priority 0x1808, read-only status 0x180C
//   status: [3:0] received levels, [7:4] positive-leg selects, [8] deep sleep
//   a read in the data phase of a write already sees the new contents
//   hsize is not checked; every write stores byte lane 0
//
// Functional notes
// - one power-down bit per receiver, bits 0 to 3, reset powered up
// - all four receivers powered down puts the section into deep sleep
// - power-down bits 7 to 4 reserved, read zero, no effect
// - fourth input family in bits 7 to 6, code 00 differential at reset
// - codes 01, 10, 11 select CMOS for rising swing ranges
// - in any CMOS family only the positive leg is sampled
// - third, second, first input families in bits 5:4, 3:2, 1:0
// - two-bit priority per reference, value equals level, reset zero
// - priority fields: fourth 7:6, third 5:4, second 3:2, first 1:0
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module ric_regs_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // reference pins
    input wire logic [3:0] refPosPin,
    input wire logic [3:0] refNegPin,
    // receiver controls
    output logic [3:0] rxPowerDown,
    output logic rxDeepSleep,
    output logic [7:0] rxFamily,
    output logic [3:0] rxPosLegOnly,
    output logic [7:0] refPriority,
    // received levels
    output logic [3:0] refLevel
);

    // ------------------------------------------------------------
    // bus state
    // ------------------------------------------------------------
    ric_pkg::ric_phase_type phase_q;
    ric_pkg::ric_phase_type phase_d;
    logic [13:0] wrAddr_q;
    logic [13:0] wrAddr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic readyOut_q;
    logic readyOut_d;
    logic resp_q;
    logic resp_d;

    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic [3:0] pwrDn_q;
    logic [3:0] pwrDn_d;
    logic sleep_q;
    logic sleep_d;
    logic [7:0] family_q;
    logic [7:0] family_d;
    logic [3:0] posOnly_q;
    logic [3:0] posOnly_d;
    logic [7:0] prio_q;
    logic [7:0] prio_d;

    // ------------------------------------------------------------
    // pin path
    // ------------------------------------------------------------
    logic [3:0] posSync;
    logic [3:0] negSync;
    logic [3:0] laneLevel;

    // ------------------------------------------------------------
    // decode and read path
    // ------------------------------------------------------------
    logic addrValid;
    logic addrMapped;
    logic [13:0] addrWord;
    logic [31:0] readValue;
    logic [31:0] statusWord;
    logic writeNow;
    logic [7:0] wrByte;

    // ------------------------------------------------------------
    // address phase decode
    // ------------------------------------------------------------
    // only address bits 13 to 2 are decoded; the 16 KB region
    // repeats above it, which keeps the comparator small
    always_comb begin
        addrWord = {haddr[13:2], 2'h0};
        addrValid = hsel && hready &&
            ((htrans == ric_pkg::HTRANS_NONSEQ) || (htrans == ric_pkg::HTRANS_SEQ));
        addrMapped = (addrWord == ric_pkg::ADDR_PWRDN) ||
            (addrWord == ric_pkg::ADDR_FAMILY) ||
            (addrWord == ric_pkg::ADDR_PRIO) ||
            (addrWord == ric_pkg::ADDR_STATUS);
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    // read-only view; writes to it get OKAY and are dropped, so software
    // polling it cannot disturb the configuration
    always_comb begin
        statusWord = 32'h00000000;
        statusWord[ric_pkg::STAT_LEVEL_LSB +: 4] = laneLevel;
        statusWord[ric_pkg::STAT_POSONLY_LSB +: 4] = posOnly_q;
        statusWord[ric_pkg::STAT_SLEEP_BIT] = sleep_q;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // fed from the next values so a read whose address phase overlaps the
    // data phase of a write returns what was just written
    always_comb begin
        readValue = 32'h00000000;
        case (addrWord)
            ric_pkg::ADDR_PWRDN: begin
                readValue[ric_pkg::PWRDN_LSB +: ric_pkg::PWRDN_W] = pwrDn_d;
            end
            ric_pkg::ADDR_FAMILY: begin
                readValue[7:0] = family_d;
            end
            ric_pkg::ADDR_PRIO: begin
                readValue[7:0] = prio_d;
            end
            ric_pkg::ADDR_STATUS: begin
                readValue = statusWord;
            end
            default: begin
                readValue = 32'h00000000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // bus phase tracking
    // ------------------------------------------------------------
    // read data is fetched in the address phase and registered, so the
    // data phase never needs a wait state; a write lands one cycle later
    // hreadyout and hresp never move after reset but stay flops, so every
    // output of the block still leaves a flip-flop
    always_comb begin
        phase_d = ric_pkg::PH_IDLE;
        wrAddr_d = wrAddr_q;
        rdata_d = rdata_q;
        readyOut_d = 1'b1;
        resp_d = ric_pkg::HRESP_OKAY;
        if (addrValid) begin
            if (hwrite && addrMapped) begin
                phase_d = ric_pkg::PH_WRITE;
                wrAddr_d = addrWord;
            end
            if (!hwrite) begin
                rdata_d = readValue;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_q <= ric_pkg::PH_IDLE;
            wrAddr_q <= 14'h0000;
            rdata_q <= 32'h00000000;
            readyOut_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            wrAddr_q <= wrAddr_d;
            rdata_q <= rdata_d;
            readyOut_q <= readyOut_d;
            resp_q <= resp_d;
        end
    end

    // ------------------------------------------------------------
    // write data phase
    // ------------------------------------------------------------
    // only byte lane 0 carries register bits; the upper lanes are ignored
    // whatever size the master announces
    always_comb begin
        writeNow = 1'b0;
        case (phase_q)
            ric_pkg::PH_WRITE: begin
                writeNow = 1'b1;
            end
            default: begin
                writeNow = 1'b0;
            end
        endcase
        wrByte = hwdata[7:0];
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_comb begin
        pwrDn_d = pwrDn_q;
        family_d = family_q;
        prio_d = prio_q;
        if (writeNow) begin
            case (wrAddr_q)
                ric_pkg::ADDR_PWRDN: begin
                    pwrDn_d = wrByte[ric_pkg::PWRDN_LSB +: ric_pkg::PWRDN_W];
                end
                ric_pkg::ADDR_FAMILY: begin
                    family_d = wrByte;
                end
                ric_pkg::ADDR_PRIO: begin
                    prio_d = wrByte;
                end
                default: begin
                    pwrDn_d = pwrDn_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // derived receiver controls
    // ------------------------------------------------------------
    // derived from the next values so they switch in step with the
    // register they depend on, never one cycle behind
    always_comb begin
        sleep_d = &pwrDn_d;
        for (int i = 0; i < ric_pkg::NUM_REF; i++) begin
            posOnly_d[i] =
                family_d[i*ric_pkg::FIELD_W +: ric_pkg::FIELD_W] != ric_pkg::FAM_DIFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sleep_q <= ric_pkg::SLEEP_RST;
            posOnly_q <= ric_pkg::POSONLY_RST;
        end else begin
            sleep_q <= sleep_d;
            posOnly_q <= posOnly_d;
        end
    end

    // ------------------------------------------------------------
    // configuration register flops
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwrDn_q <= ric_pkg::PWRDN_RST;
            family_q <= ric_pkg::FAMILY_RST;
            prio_q <= ric_pkg::PRIO_RST;
        end else begin
            pwrDn_q <= pwrDn_d;
            family_q <= family_d;
            prio_q <= prio_d;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // the legs are not related to clk, so both pass two flops before any
    // lane reads them
    ric_sync2 #(
        .WIDTH(4)
    ) uPosSync (
        .clk(clk),
        .nrst(nrst),
        .asyncIn(refPosPin),
        .syncOut(posSync)
    );

    ric_sync2 #(
        .WIDTH(4)
    ) uNegSync (
        .clk(clk),
        .nrst(nrst),
        .asyncIn(refNegPin),
        .syncOut(negSync)
    );

    // ------------------------------------------------------------
    // receiver lanes
    // ------------------------------------------------------------
    // lanes read the registered controls, so a configuration change
    // reaches the received level two cycles after the write phase
    for (genvar g = 0; g < ric_pkg::NUM_REF; g++) begin : gLane
        logic [1:0] laneFamily;
        logic laneDown;
        assign laneFamily = family_q[g*ric_pkg::FIELD_W +: ric_pkg::FIELD_W];
        assign laneDown = pwrDn_q[g];
        ric_rx_lane uLane (
            .clk(clk),
            .nrst(nrst),
            .posLeg(posSync[g]),
            .negLeg(negSync[g]),
            .family(laneFamily),
            .powerDown(laneDown),
            .deepSleep(sleep_q),
            .level(laneLevel[g])
        );
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata = rdata_q;
    assign hreadyout = readyOut_q;
    assign hresp = resp_q;
    assign rxPowerDown = pwrDn_q;
    assign rxDeepSleep = sleep_q;
    assign rxFamily = family_q;
    assign rxPosLegOnly = posOnly_q;
    assign refPriority = prio_q;
    assign refLevel = laneLevel;

endmodule // ric_regs_top

// ===== ric_rx_lane.sv
// Purpose: one reference receiver front end
// Assumes: pin legs already synchronised
// Notes: level output is registered
`timescale 1ns/1ps
module ric_rx_lane (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // synchronised legs
    input wire logic posLeg,
    input wire logic negLeg,
    // configuration
    input wire logic [1:0] family,
    input wire logic powerDown,
    input wire logic deepSleep,
    // result
    output logic level
);

    logic level_q;
    logic level_d;

    always_comb begin
        level_d = level_q;
        if (powerDown || deepSleep) begin
            // a parked receiver presents a quiet low
            level_d = 1'b0;
        end else if (family != ric_pkg::FAM_DIFF) begin
            level_d = posLeg;
        end else if (posLeg != negLeg) begin
            // differential reception; equal legs hold last state
            level_d = posLeg;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

    assign level = level_q;

endmodule // ric_rx_lane

// ===== ric_sync2.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module ric_sync2 #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage1_d;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage2_d;

    always_comb begin
        stage1_d = asyncIn;
        stage2_d = stage1_q;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign syncOut = stage2_q;

endmodule // ric_sync2

// ===== tb_ric.sv
// Purpose: self-checking bench for the reference input configuration registers
// Assumes: bus master waits on hreadyout, pins driven directly
// Notes: reset reads first, then table rows, then pins and a second reset
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [13:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic [3:0] pl;
        logic s;
    } ric_tb_row_type;
    // address, write data, read back, positive-leg selects, deep sleep
    localparam ric_tb_row_type ROWS [8] = '{
        '{ric_pkg::ADDR_PWRDN, 8'hFF, 8'h0F, 4'h0, 1'b1},
        '{ric_pkg::ADDR_PWRDN, 8'hF5, 8'h05, 4'h0, 1'b0},
        '{ric_pkg::ADDR_FAMILY, 8'hE4, 8'hE4, 4'hE, 1'b0},
        '{ric_pkg::ADDR_FAMILY, 8'h1B, 8'h1B, 4'h7, 1'b0},
        '{ric_pkg::ADDR_FAMILY, 8'h40, 8'h40, 4'h8, 1'b0},
        '{ric_pkg::ADDR_PRIO, 8'hE4, 8'hE4, 4'h8, 1'b0},
        '{ric_pkg::ADDR_PRIO, 8'h1B, 8'h1B, 4'h8, 1'b0},
        '{14'h1810, 8'hAA, 8'h00, 4'h8, 1'b0}
    };
    logic clk, nrst, hsel, hwrite, hreadyout, hresp, rxDeepSleep;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] refPosPin, refNegPin, rxPowerDown, rxPosLegOnly, refLevel;
    logic [7:0] rxFamily, refPriority;
    int checks, miscompares;

    ric_regs_top u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .refPosPin(refPosPin), .refNegPin(refNegPin),
        .rxPowerDown(rxPowerDown), .rxDeepSleep(rxDeepSleep), .rxFamily(rxFamily),
        .rxPosLegOnly(rxPosLegOnly), .refPriority(refPriority), .refLevel(refLevel));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // a hung slave counts as a mismatch and ends the run
    task waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask

    task bus(input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= ric_pkg::HTRANS_NONSEQ;
        haddr <= {18'h0, a};
        hwrite <= w;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        r = hrdata;
    endtask

    task resetRead(input int n);
        nrst <= 1'b0;
        repeat (n) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, ric_pkg::ADDR_PWRDN, 32'h0, rd);
        chk("pwrdnReset", 32'h0, rd);
        bus(1'b0, ric_pkg::ADDR_FAMILY, 32'h0, rd);
        chk("familyReset", 32'h0, rd);
        bus(1'b0, ric_pkg::ADDR_PRIO, 32'h0, rd);
        chk("prioReset", 32'h0, rd);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        refPosPin = 4'h0;
        refNegPin = 4'h0;
        checks = 0;
        miscompares = 0;
        resetRead(20);
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i].a, {24'h0, ROWS[i].d}, rd);
            bus(1'b0, ROWS[i].a, 32'h0, rd);
            chk("readback", {24'h0, ROWS[i].r}, rd);
            chk("posLegOnly", {28'h0, ROWS[i].pl}, {28'h0, rxPosLegOnly});
            chk("deepSleep", {31'h0, ROWS[i].s}, {31'h0, rxDeepSleep});
        end
        // all lanes single-ended, negative legs must not matter
        bus(1'b1, ric_pkg::ADDR_FAMILY, 32'h55, rd);
        bus(1'b1, ric_pkg::ADDR_PWRDN, 32'h00, rd);
        refPosPin <= 4'h5;
        refNegPin <= 4'h5;
        repeat (4) @(posedge clk);
        chk("levelCmos", 32'h5, {28'h0, refLevel});
        refNegPin <= 4'hA;
        repeat (4) @(posedge clk);
        chk("levelNegIgnored", 32'h5, {28'h0, refLevel});
        bus(1'b1, ric_pkg::ADDR_PWRDN, 32'h03, rd);
        repeat (3) @(posedge clk);
        chk("levelLaneDown", 32'h4, {28'h0, refLevel});
        bus(1'b1, ric_pkg::ADDR_PWRDN, 32'h0F, rd);
        repeat (3) @(posedge clk);
        chk("levelSleep", 32'h0, {28'h0, refLevel});
        bus(1'b0, ric_pkg::ADDR_STATUS, 32'h0, rd);
        chk("status", 32'h000001F0, rd);
        // differential again: level follows the positive leg while the legs differ
        bus(1'b1, ric_pkg::ADDR_FAMILY, 32'h00, rd);
        bus(1'b1, ric_pkg::ADDR_PWRDN, 32'h00, rd);
        repeat (4) @(posedge clk);
        chk("levelDiff", 32'h5, {28'h0, refLevel});
        refPosPin <= 4'hA;
        refNegPin <= 4'hA;
        repeat (4) @(posedge clk);
        chk("levelDiffHold", 32'h5, {28'h0, refLevel});
        refNegPin <= 4'h5;
        repeat (4) @(posedge clk);
        chk("levelDiffSwap", 32'hA, {28'h0, refLevel});
        resetRead(3);
        conclude();
    end
endmodule // tb
